// File: cfmg_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - two sources, one routed to all outputs
// - select low hstl, select high pecl
// - gate sampled on source rising edge
// - start or stop only while outputs low
// - nine pairs carry same clock in phase
// - open select, gate, complements read high
// - open true clock inputs read low

// two-input clock mux feeding nine gated differential pairs
// all pins are sampled on the one system clock; a source "edge"
// is a change of its synchronised level, so sources must run well
// below half the system clock rate to be seen at all
module cfmg_top #(
  parameter int unsigned NUM_OUT = cfmg_pkg::NUM_OUT
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // raw board levels, one field per pin
  input wire cfmg_pkg::cfmg_pins_s pin_i,
  // high where the board really drives the pin
  input wire cfmg_pkg::cfmg_pins_s driven_i,
  output logic [NUM_OUT-1:0] fanout_outputs_t_o,
  output logic [NUM_OUT-1:0] fanout_outputs_c_o
);
  // state of the mux and gate core, sized by the output count
  typedef struct packed {
    logic src_prev;
    logic gate_smp;
    logic gate_on;
    logic [NUM_OUT-1:0] out_t;
    logic [NUM_OUT-1:0] out_c;
  } cfmg_core_loc_s;

  // level an open clock pair presents, so no false edge after reset
  localparam logic SRC_IDLE = cfmg_pkg::PIN_PULL[cfmg_pkg::PIN_HSTL_P] &
                              ~cfmg_pkg::PIN_PULL[cfmg_pkg::PIN_HSTL_N];

  // core reset: gate off, true outputs low, complements high
  localparam cfmg_core_loc_s CORE_RST = '{
    src_prev: SRC_IDLE,
    gate_smp: cfmg_pkg::GATE_RST,
    gate_on: cfmg_pkg::GATE_RST,
    out_t: {NUM_OUT{cfmg_pkg::OUT_T_RST[0]}},
    out_c: {NUM_OUT{cfmg_pkg::OUT_C_RST[0]}}
  };

  // differential pair to one level; an open pair reads low
  function automatic logic diff_level(input logic p, input logic n);
    diff_level = p & ~n;
  endfunction

  // synchronised pin vector, already resolved to pull levels
  logic [cfmg_pkg::NUM_PIN-1:0] sync_w;
  // same vector seen through the pin carrier
  cfmg_pkg::cfmg_pins_s lvl_w;
  // decoded level of the hstl-level pair
  logic hstl_w;
  // decoded level of the pecl-level pair
  logic pecl_w;
  // currently selected source
  logic src_w;
  // one-cycle pulse on a rising edge of the selected source
  logic rise_w;
  // next and current core state
  cfmg_core_loc_s core_d;
  cfmg_core_loc_s core_q;

  // two flip-flops per pin and per drive flag, then pulls
  cfmg_pin_sync #(
    .WIDTH(cfmg_pkg::NUM_PIN),
    .PULL(cfmg_pkg::PIN_PULL)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin_i),
    .driven_i(driven_i),
    .sync_o(sync_w)
  );

  // view the flat vector as named pins
  assign lvl_w = cfmg_pkg::cfmg_pins_s'(sync_w);

  assign hstl_w = diff_level(lvl_w.hstl_p, lvl_w.hstl_n);
  assign pecl_w = diff_level(lvl_w.pecl_p, lvl_w.pecl_n);

  // static select
  // select is not glitch-protected: change it only while gated off
  assign src_w = (lvl_w.sel == cfmg_pkg::SEL_PECL) ? pecl_w : hstl_w;

  // edges of the selected source only
  // a stopped source therefore freezes the gate where it stands
  assign rise_w = src_w & ~core_q.src_prev;

  // next state of the core
  always_comb begin
    core_d = core_q;
    // remember the source level for edge detection
    core_d.src_prev = src_w;
    if (rise_w) begin
      core_d.gate_smp = lvl_w.gate;
    end
    // apply gate while low
    // taking the sample only in the low phase keeps every pulse whole
    if (!src_w) begin
      core_d.gate_on = core_q.gate_smp;
    end
    core_d.out_t = {NUM_OUT{core_d.gate_on & src_w}};
    core_d.out_c = ~core_d.out_t;
  end

  // core register; the reset branch loads a constant only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_q <= CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  // outputs straight from the core flip-flops
  assign fanout_outputs_t_o = core_q.out_t;
  assign fanout_outputs_c_o = core_q.out_c;

  pair_complement_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fanout_outputs_c_o == ~fanout_outputs_t_o)
    else $error("complement output is not the inverse of the true output");

  pairs_in_phase_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (fanout_outputs_t_o == '0) || (fanout_outputs_t_o == '1))
    else $error("true outputs differ from one another");

  disabled_low_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !core_q.gate_on |-> (fanout_outputs_t_o == '0))
    else $error("output high while gated off");

  gate_moves_low_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(core_q.gate_on) |-> !$past(src_w))
    else $error("gate changed while the source was high");

  gate_on_rise_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(core_q.gate_smp) |-> $past(rise_w))
    else $error("gate sample taken outside a source rising edge");

  out_follows_src_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (fanout_outputs_t_o != '0) |-> $past(src_w))
    else $error("output high while the selected source was low");

  hstl_route_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ((fanout_outputs_t_o != '0) && ($past(lvl_w.sel) != cfmg_pkg::SEL_PECL)) |-> $past(hstl_w))
    else $error("output high with hstl selected but hstl low");

  // gate turning on
  gate_on_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(core_q.gate_on));
  // gate turning off
  gate_off_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $fell(core_q.gate_on));
  // pecl clock reaching the outputs
  pecl_out_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fanout_outputs_t_o != '0) && ($past(lvl_w.sel) == cfmg_pkg::SEL_PECL));
  // hstl clock reaching the outputs
  hstl_out_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fanout_outputs_t_o != '0) && ($past(lvl_w.sel) != cfmg_pkg::SEL_PECL));
endmodule

// two flip-flops on every pin and on its drive flag, then pull resolve
// the resolve sits after the flops so no logic reads a raw pin
module cfmg_pin_sync #(
  parameter int unsigned WIDTH = cfmg_pkg::NUM_PIN,
  parameter logic [WIDTH-1:0] PULL = cfmg_pkg::PIN_PULL
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] driven_i,
  output logic [WIDTH-1:0] sync_o
);
  // synchroniser state sized by the pin count
  typedef struct packed {
    logic [WIDTH-1:0] pin_meta;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] drv_meta;
    logic [WIDTH-1:0] drv_sync;
  } cfmg_sync_loc_s;

  // reset: every pin open, so it reads its pull level
  localparam cfmg_sync_loc_s SYNC_RST = '{
    pin_meta: PULL,
    pin_sync: PULL,
    drv_meta: '0,
    drv_sync: '0
  };

  // next and current synchroniser state
  cfmg_sync_loc_s sync_d;
  cfmg_sync_loc_s sync_q;

  // first stage takes the pins, second stage reads only the first
  always_comb begin
    sync_d = sync_q;
    sync_d.pin_meta = pin_i;
    sync_d.pin_sync = sync_q.pin_meta;
    sync_d.drv_meta = driven_i;
    sync_d.drv_sync = sync_q.drv_meta;
  end

  // synchroniser register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_q <= SYNC_RST;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign sync_o = (sync_q.pin_sync & sync_q.drv_sync) | (PULL & ~sync_q.drv_sync);
endmodule
`default_nettype wire

// File: cfmg_pkg.sv
`default_nettype none
package cfmg_pkg;
  // number of identical differential output pairs
  localparam int unsigned NUM_OUT = 9;
  // number of board pins that pass the input synchroniser
  localparam int unsigned NUM_PIN = 6;

  // bit positions of each pin in the synchronised pin vector
  localparam int unsigned PIN_HSTL_P = 0;
  localparam int unsigned PIN_HSTL_N = 1;
  localparam int unsigned PIN_PECL_P = 2;
  localparam int unsigned PIN_PECL_N = 3;
  localparam int unsigned PIN_SEL = 4;
  localparam int unsigned PIN_GATE = 5;

  // level an open pin reads: complements, select and gate high, true clocks low
  localparam logic [NUM_PIN-1:0] PIN_PULL = 6'h3a;

  // select value that picks the pecl-level source
  localparam logic SEL_PECL = 1'h1;

  // reset values
  localparam logic GATE_RST = 1'h0;
  localparam logic [NUM_OUT-1:0] OUT_T_RST = 9'h000;
  localparam logic [NUM_OUT-1:0] OUT_C_RST = 9'h1ff;

  // board pins as one carrier, msb first
  typedef struct packed {
    logic gate;
    logic sel;
    logic pecl_n;
    logic pecl_p;
    logic hstl_n;
    logic hstl_p;
  } cfmg_pins_s;

  // state of the pin synchroniser
  typedef struct packed {
    logic [NUM_PIN-1:0] meta;
    logic [NUM_PIN-1:0] sync;
  } cfmg_sync_s;

  // state of the mux and gate core
  typedef struct packed {
    logic src_prev;
    logic gate_smp;
    logic gate_on;
    logic [NUM_OUT-1:0] out_t;
    logic [NUM_OUT-1:0] out_c;
  } cfmg_core_s;
endpackage
`default_nettype wire

// File: cfmg_board.sv
`timescale 1ns/1ps
`default_nettype none
// board wires: an undriven pin falls to its pull level
module cfmg_board (
  input wire logic [5:0] pin_i,
  input wire logic [5:0] drv_i,
  output logic [5:0] lvl_o
);
  assign lvl_o = (pin_i & drv_i) | (cfmg_pkg::PIN_PULL & ~drv_i);
endmodule
`default_nettype wire

// File: clock_fanout_mux_gate_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_fanout_mux_gate_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cfmg_pkg::cfmg_pins_s pin = '0;
  cfmg_pkg::cfmg_pins_s drv = '0;
  logic [5:0] lvl;
  logic [8:0] out_t;
  logic [8:0] out_c;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int hcnt = 0;
  int pcnt = 0;
  // reference model: two-deep pin delay and core state
  logic [5:0] q[$];
  logic m_prev = 1'b0;
  logic m_smp = 1'b0;
  logic m_on = 1'b0;
  logic m_out = 1'b0;
  always #50 ref_clk_i = ~ref_clk_i;
  // partner: board pulls on open pins
  cfmg_board B (.pin_i(pin), .drv_i(drv), .lvl_o(lvl));
  cfmg_top DUT (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin),
    .driven_i(drv),
    .fanout_outputs_t_o(out_t),
    .fanout_outputs_c_o(out_c)
  );
  task automatic model_reset();
    q = '{cfmg_pkg::PIN_PULL, cfmg_pkg::PIN_PULL};
    m_prev = 1'b0;
    m_smp = 1'b0;
    m_on = 1'b0;
    m_out = 1'b0;
  endtask
  // model step on each rising edge, from levels two edges old
  always @(posedge ref_clk_i) begin
    logic [5:0] v;
    logic s;
    if (rst_n_i) begin
      q.push_back(lvl);
      v = q.pop_front();
      if (v[cfmg_pkg::PIN_SEL]) s = v[cfmg_pkg::PIN_PECL_P] && !v[cfmg_pkg::PIN_PECL_N];
      else s = v[cfmg_pkg::PIN_HSTL_P] && !v[cfmg_pkg::PIN_HSTL_N];
      if (s && !m_prev) m_smp = v[cfmg_pkg::PIN_GATE];
      if (!s) m_on = m_smp;
      m_out = m_on && s;
      m_prev = s;
    end
  end
  task automatic check_outs(input logic exp);
    tests_run++;
    if (out_t !== {9{exp}} || out_c !== ~{9{exp}}) begin
      errors++;
      $display("ERROR %0t outputs %h %h expected %b", $time, out_t, out_c, exp);
    end
  endtask
  // sources divide the system clock; gate changes at random, select only when sel_mode is 2
  task automatic drive_step(input int sel_mode, input int open_pins);
    if (++hcnt >= 3) begin hcnt = 0; pin.hstl_p = ~pin.hstl_p; end
    if (++pcnt >= 5) begin pcnt = 0; pin.pecl_p = ~pin.pecl_p; end
    pin.hstl_n = ~pin.hstl_p;
    pin.pecl_n = ~pin.pecl_p;
    if ($urandom % 16 == 0) pin.gate = 1'($urandom);
    if (sel_mode < 2) pin.sel = 1'(sel_mode);
    else if ($urandom % 32 == 0) pin.sel = ~pin.sel;
    drv = open_pins ? cfmg_pkg::cfmg_pins_s'(6'($urandom)) : cfmg_pkg::cfmg_pins_s'(6'h3f);
  endtask
  task automatic run_test(input int n, input int sel_mode, input int open_pins);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk_i);
      check_outs(m_out);
      drive_step(sel_mode, open_pins);
    end
  endtask
  task tally_and_finish;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the 1400 cycles the tests need
  always @(posedge ref_clk_i) if (++cyc > 3000) begin errors++; tally_and_finish; end
  initial begin
    void'($urandom(32'h1c7a));
    model_reset();
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    run_test(400, 0, 0);
    $display("test hstl source done");
    run_test(400, 1, 0);
    $display("test pecl source done");
    run_test(200, 1, 1);
    $display("test open pins done");
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    model_reset();
    rst_n_i = 1'b1;
    run_test(400, 2, 0);
    $display("test reset and random select done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
